// File: mbt_pkg.sv
// Shared constants, carriers and state types of the marker block transfer engine
package mbt_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_CH = 32;
  localparam int CH_W = 5;
  localparam int OFS_W = 16;
  localparam int CNT_W = 16;
  localparam int MAX_COUNT = 1024;
  localparam int MEM_BYTES_DEF = 512;

  // ************************************************************
  // Register map (byte addresses, low 12 bits of haddr)
  // ************************************************************
  localparam logic [11:0] REG_SRC = 12'h000;
  localparam logic [11:0] REG_DST = 12'h004;
  localparam logic [11:0] REG_CNT = 12'h008;
  localparam logic [11:0] REG_CTRL = 12'h00C;
  localparam int CH_SEL_LO = 4;
  localparam int CH_SEL_HI = 8;
  localparam logic [11:0] REG_IRQ_STATUS = 12'h200;
  localparam logic [11:0] REG_IRQ_MASK = 12'h204;
  localparam logic [11:0] REG_ENGINE = 12'h208;
  localparam logic [11:0] CH_AREA_END = 12'h200;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_TRIGGER_BIT = 1;
  localparam int CTRL_FILL_BIT = 2;
  localparam int CTRL_ENREQ_BIT = 3;
  localparam int STAT_E1_BIT = 8;
  localparam int STAT_E2_BIT = 9;
  localparam int STAT_E3_BIT = 10;
  localparam int STAT_PEND_BIT = 11;
  localparam int STAT_BUSY_BIT = 12;
  localparam int ENG_BUSY_BIT = 0;
  localparam int ENG_CH_LO = 8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [OFS_W-1:0] OFS_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
  localparam logic HREADYOUT_RESET = 1'b1;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic en_required;
    logic fill_mode;
    logic trigger;
    logic enable;
  } mbt_ctrl_t;

  typedef struct packed {
    logic [OFS_W-1:0] source_offset;
    logic [OFS_W-1:0] dest_offset;
    logic [CNT_W-1:0] count;
    mbt_ctrl_t ctrl;
  } mbt_cfg_t;

  typedef struct packed {
    logic marker_bounds_error;
    logic overlap_error;
    logic count_range_error;
  } mbt_err_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [OFS_W-1:0] addr;
    logic [7:0] wdata;
  } mbt_mem_req_t;

  typedef struct packed {
    logic trig_prev;
    logic pending;
  } mbt_chan_state_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_READ = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_CAPT = 5'b01000,
    ST_WRITE = 5'b10000
  } mbt_state_t;

endpackage

// File: mbt_channel.sv
// One block transfer channel: parameter checks and trigger edge detection
`timescale 1ns/100ps
module mbt_channel #(
  parameter int MEM_BYTES = mbt_pkg::MEM_BYTES_DEF
) (
  // Clock, reset and clock enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Configuration
  input wire mbt_pkg::mbt_cfg_t cfg,
  // Engine handshake
  input wire logic grant,
  output logic pending,
  output logic active,
  output mbt_pkg::mbt_err_t err
);

  // ************************************************************
  // Parameter checks
  // ************************************************************
  localparam logic [17:0] MEM_LIMIT = 18'(MEM_BYTES);
  localparam logic [17:0] COUNT_LIMIT = 18'(mbt_pkg::MAX_COUNT);

  logic [17:0] src_w;
  logic [17:0] dst_w;
  logic [17:0] cnt_w;
  logic [17:0] src_end;
  logic [17:0] dst_end;
  logic err_any;
  logic rise;
  mbt_pkg::mbt_chan_state_t r;
  mbt_pkg::mbt_chan_state_t next_r;

  // Wide sums so that offset plus count never wraps
  always_comb begin
    src_w = {2'b00, cfg.source_offset};
    dst_w = {2'b00, cfg.dest_offset};
    cnt_w = {2'b00, cfg.count};
    src_end = src_w + cnt_w;
    dst_end = dst_w + cnt_w;
    err.count_range_error = (cnt_w > COUNT_LIMIT) || (dst_end > MEM_LIMIT)
      || (!cfg.ctrl.fill_mode && (src_end > MEM_LIMIT));
    if (cfg.ctrl.fill_mode) begin
      err.overlap_error = (src_w >= dst_w) && (src_w < dst_end);
    end else begin
      err.overlap_error = (src_w < dst_end) && (dst_w < src_end);
    end
    err.marker_bounds_error = (cnt_w == 18'h00000) || (src_w >= MEM_LIMIT)
      || (dst_w >= MEM_LIMIT);
    err_any = err.count_range_error || err.overlap_error || err.marker_bounds_error;
  end

  // ************************************************************
  // Trigger edge and pending request
  // ************************************************************
  always_comb begin
    active = cfg.ctrl.en_required ? cfg.ctrl.enable : 1'b1;
    rise = cfg.ctrl.trigger && !r.trig_prev;
    next_r.trig_prev = cfg.ctrl.trigger;
    // A new edge wins over the grant that clears the old request
    next_r.pending = (rise && active && !err_any)
      || (r.pending && !grant && !err_any);
    pending = r.pending;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

endmodule // mbt_channel

// File: mbt_top.sv
// Marker block transfer engine: 32 channels, shared byte engine, AHB-Lite registers
`timescale 1ns/100ps

// Function
// - Thirty-two independent channels, each with own inputs, mode and error flags.
// - Fill mode copies one marker byte into every byte of the destination.
// - Data moves one byte per step, never as words.
// - Source from source offset, destination from dest offset, length from count.
// - Offsets count from the first marker byte; zero is marker byte one.
// - Parameters checked continuously; faults on three error flags.
// - Always operates on marker bytes regardless of operand type.
// - With enable evaluation on, the channel works only while enable is one.
// - One transfer per rising trigger edge; levels and falling edges do nothing.
// - Fill mode reads one source byte; count sets only destination length.
// - Copy mode copies count bytes in order from source to destination.
// - Overlapping source and destination ranges raise the overlap error.
// - No fill or copy while any error flag is active.
// - Zero count or an out-of-bounds source or dest offset raises the bounds error; a range ending past memory raises the count range error.
// - With enable evaluation off, the channel is always enabled.
module mbt_top #(
  parameter int MEM_BYTES = mbt_pkg::MEM_BYTES_DEF
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Marker memory byte port
  output mbt_pkg::mbt_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  // Status
  output logic irq,
  output logic engine_busy,
  output logic [31:0] count_range_error,
  output logic [31:0] overlap_error,
  output logic [31:0] marker_bounds_error
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [mbt_pkg::NUM_CH-1:0][mbt_pkg::OFS_W-1:0] src;
    logic [mbt_pkg::NUM_CH-1:0][mbt_pkg::OFS_W-1:0] dst;
    logic [mbt_pkg::NUM_CH-1:0][mbt_pkg::CNT_W-1:0] cnt;
    logic [mbt_pkg::NUM_CH-1:0][3:0] ctrl;
    logic [31:0] irq_status;
    logic [31:0] irq_mask;
    logic irq;
    logic dp_valid;
    logic dp_write;
    logic [11:0] dp_addr;
    logic hreadyout;
    logic [31:0] hrdata;
    mbt_pkg::mbt_state_t state;
    logic [mbt_pkg::CH_W-1:0] ch;
    logic fill;
    logic [mbt_pkg::OFS_W-1:0] xsrc;
    logic [mbt_pkg::OFS_W-1:0] xdst;
    logic [mbt_pkg::CNT_W-1:0] xcnt;
    logic [mbt_pkg::CNT_W-1:0] idx;
    logic [7:0] data;
    mbt_pkg::mbt_mem_req_t mem;
    logic busy;
    logic [31:0] e1;
    logic [31:0] e2;
    logic [31:0] e3;
  } mbt_top_state_t;

  mbt_top_state_t r;
  mbt_top_state_t next_r;

  mbt_pkg::mbt_cfg_t [mbt_pkg::NUM_CH-1:0] cfg;
  mbt_pkg::mbt_err_t [mbt_pkg::NUM_CH-1:0] err;
  logic [mbt_pkg::NUM_CH-1:0] pending;
  logic [mbt_pkg::NUM_CH-1:0] active;
  logic [mbt_pkg::NUM_CH-1:0] grant;

  // ************************************************************
  // Channels
  // ************************************************************
  for (genvar i = 0; i < mbt_pkg::NUM_CH; i++) begin : g_ch
    always_comb begin
      cfg[i].source_offset = r.src[i];
      cfg[i].dest_offset = r.dst[i];
      cfg[i].count = r.cnt[i];
      cfg[i].ctrl = mbt_pkg::mbt_ctrl_t'(r.ctrl[i]);
    end
    mbt_channel #(
      .MEM_BYTES(MEM_BYTES)
    ) u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .cfg(cfg[i]),
      .grant(grant[i]),
      .pending(pending[i]),
      .active(active[i]),
      .err(err[i])
    );
  end

  // ************************************************************
  // Next state
  // ************************************************************
  logic [mbt_pkg::CH_W-1:0] ch_a;
  logic [1:0] sel_a;
  logic [31:0] irq_clr;
  logic [31:0] done_set;
  logic [31:0] rdval;
  logic [mbt_pkg::CH_W-1:0] pick;
  logic found;
  logic ch_err;
  logic last;

  always_comb begin
    next_r = r;
    grant = '0;
    irq_clr = 32'h00000000;
    done_set = 32'h00000000;
    rdval = 32'h00000000;
    ch_a = r.dp_addr[mbt_pkg::CH_SEL_HI:mbt_pkg::CH_SEL_LO];
    sel_a = r.dp_addr[3:2];
    pick = '0;
    found = 1'b0;
    last = 1'b0;
    next_r.mem.rd_en = 1'b0;
    next_r.mem.wr_en = 1'b0;

    // Bus data phase: one wait state so that a frozen clock enable holds the bus
    if (r.dp_valid) begin
      next_r.dp_valid = 1'b0;
      next_r.hreadyout = 1'b1;
      if (r.dp_write) begin
        if (r.dp_addr < mbt_pkg::CH_AREA_END) begin
          case (sel_a)
            2'b00: next_r.src[ch_a] = hwdata[mbt_pkg::OFS_W-1:0];
            2'b01: next_r.dst[ch_a] = hwdata[mbt_pkg::OFS_W-1:0];
            2'b10: next_r.cnt[ch_a] = hwdata[mbt_pkg::CNT_W-1:0];
            default: next_r.ctrl[ch_a] = hwdata[3:0];
          endcase
        end else if (r.dp_addr == mbt_pkg::REG_IRQ_STATUS) begin
          irq_clr = hwdata;
        end else if (r.dp_addr == mbt_pkg::REG_IRQ_MASK) begin
          next_r.irq_mask = hwdata;
        end
      end else begin
        if (r.dp_addr < mbt_pkg::CH_AREA_END) begin
          case (sel_a)
            2'b00: rdval[mbt_pkg::OFS_W-1:0] = r.src[ch_a];
            2'b01: rdval[mbt_pkg::OFS_W-1:0] = r.dst[ch_a];
            2'b10: rdval[mbt_pkg::CNT_W-1:0] = r.cnt[ch_a];
            default: begin
              rdval[3:0] = r.ctrl[ch_a];
              rdval[mbt_pkg::STAT_E1_BIT] = err[ch_a].count_range_error;
              rdval[mbt_pkg::STAT_E2_BIT] = err[ch_a].overlap_error;
              rdval[mbt_pkg::STAT_E3_BIT] = err[ch_a].marker_bounds_error;
              rdval[mbt_pkg::STAT_PEND_BIT] = pending[ch_a];
              rdval[mbt_pkg::STAT_BUSY_BIT] = r.busy && (r.ch == ch_a);
            end
          endcase
        end else if (r.dp_addr == mbt_pkg::REG_IRQ_STATUS) begin
          rdval = r.irq_status;
        end else if (r.dp_addr == mbt_pkg::REG_IRQ_MASK) begin
          rdval = r.irq_mask;
        end else if (r.dp_addr == mbt_pkg::REG_ENGINE) begin
          rdval[mbt_pkg::ENG_BUSY_BIT] = r.busy;
          rdval[mbt_pkg::ENG_CH_LO +: mbt_pkg::CH_W] = r.ch;
        end
        next_r.hrdata = rdval;
      end
    end
    // Address phase
    if (hsel && htrans[1] && hready && r.hreadyout) begin
      next_r.dp_valid = 1'b1;
      next_r.dp_write = hwrite;
      next_r.dp_addr = {haddr[11:2], 2'b00};
      next_r.hreadyout = 1'b0;
    end

    // Lowest pending channel goes first
    for (int i = mbt_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (pending[i]) begin
        pick = i[mbt_pkg::CH_W-1:0];
        found = 1'b1;
      end
    end

    ch_err = err[r.ch].count_range_error || err[r.ch].overlap_error
      || err[r.ch].marker_bounds_error;

    // Byte engine
    case (r.state)
      mbt_pkg::ST_IDLE: begin
        if (found) begin
          grant[pick] = 1'b1;
          next_r.ch = pick;
          next_r.fill = r.ctrl[pick][mbt_pkg::CTRL_FILL_BIT];
          next_r.xsrc = r.src[pick];
          next_r.xdst = r.dst[pick];
          next_r.xcnt = r.cnt[pick];
          next_r.idx = '0;
          next_r.busy = 1'b1;
          next_r.state = mbt_pkg::ST_READ;
        end
      end
      mbt_pkg::ST_READ: begin
        if (ch_err) begin
          next_r.busy = 1'b0;
          next_r.state = mbt_pkg::ST_IDLE;
        end else if (active[r.ch]) begin
          next_r.mem.rd_en = 1'b1;
          // Fill reads the one source byte; copy walks the source
          next_r.mem.addr = r.fill ? r.xsrc : r.xsrc + r.idx;
          next_r.state = mbt_pkg::ST_WAIT;
        end
      end
      mbt_pkg::ST_WAIT: begin
        next_r.state = mbt_pkg::ST_CAPT;
      end
      mbt_pkg::ST_CAPT: begin
        next_r.data = mem_rdata;
        next_r.state = mbt_pkg::ST_WRITE;
      end
      mbt_pkg::ST_WRITE: begin
        if (ch_err) begin
          next_r.busy = 1'b0;
          next_r.state = mbt_pkg::ST_IDLE;
        end else if (active[r.ch]) begin
          next_r.mem.wr_en = 1'b1;
          next_r.mem.addr = r.xdst + r.idx;
          next_r.mem.wdata = r.data;
          next_r.idx = r.idx + 16'h0001;
          last = (r.idx + 16'h0001) == r.xcnt;
          if (last) begin
            next_r.busy = 1'b0;
            done_set[r.ch] = 1'b1;
            next_r.state = mbt_pkg::ST_IDLE;
          end else if (r.fill) begin
            next_r.state = mbt_pkg::ST_WRITE;
          end else begin
            next_r.state = mbt_pkg::ST_READ;
          end
        end
      end
      default: begin
        next_r.busy = 1'b0;
        next_r.state = mbt_pkg::ST_IDLE;
      end
    endcase

    // Done events: set wins over a clear in the same cycle
    next_r.irq_status = (r.irq_status & ~irq_clr) | done_set;
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);

    for (int i = 0; i < mbt_pkg::NUM_CH; i++) begin
      next_r.e1[i] = err[i].count_range_error;
      next_r.e2[i] = err[i].overlap_error;
      next_r.e3[i] = err[i].marker_bounds_error;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.hreadyout <= mbt_pkg::HREADYOUT_RESET;
      r.irq_mask <= mbt_pkg::IRQ_MASK_RESET;
      r.state <= mbt_pkg::ST_IDLE;
      for (int i = 0; i < mbt_pkg::NUM_CH; i++) begin
        r.src[i] <= mbt_pkg::OFS_RESET;
        r.dst[i] <= mbt_pkg::OFS_RESET;
        r.cnt[i] <= mbt_pkg::CNT_RESET;
        r.ctrl[i] <= mbt_pkg::CTRL_RESET;
      end
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_comb begin
    hreadyout = r.hreadyout;
    hrdata = r.hrdata;
    hresp = 1'b0;
    mem_req = r.mem;
    irq = r.irq;
    engine_busy = r.busy;
    count_range_error = r.e1;
    overlap_error = r.e2;
    marker_bounds_error = r.e3;
  end

endmodule // mbt_top

// File: mbt_top_assertions.sv
// Concurrent checks on the ports of the marker block transfer engine
`timescale 1ns/100ps
module mbt_top_chk #(
  parameter int MEM_BYTES = 512
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Memory and status
  input wire mbt_pkg::mbt_mem_req_t mem_req,
  input wire logic irq,
  input wire logic engine_busy,
  input wire logic [31:0] count_range_error,
  input wire logic [31:0] overlap_error
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic taken;
  assign taken = hsel && htrans[1] && hready && hreadyout && ce;
  // ************************************************************
  // Bus
  // ************************************************************
  property p_hresp_okay; hresp == 1'b0; endproperty
  a_hresp_okay: assert property (p_hresp_okay) else $error("hresp not okay");
  property p_ready_low; taken |=> !hreadyout; endproperty
  a_ready_low: assert property (p_ready_low) else $error("no wait state");
  property p_ready_high; !hreadyout && ce |=> hreadyout; endproperty
  a_ready_high: assert property (p_ready_high) else $error("wait too long");
  property p_rdata_hold; !$stable(hrdata) |-> !$past(hreadyout); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved");
  // ************************************************************
  // Byte engine
  // ************************************************************
  property p_rd_pulse; mem_req.rd_en |=> !mem_req.rd_en; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read not a pulse");
  property p_no_both; !(mem_req.rd_en && mem_req.wr_en); endproperty
  a_no_both: assert property (p_no_both) else $error("read and write together");
  property p_addr_bound; mem_req.rd_en || mem_req.wr_en |-> mem_req.addr < MEM_BYTES; endproperty
  a_addr_bound: assert property (p_addr_bound) else $error("address out of memory");
  property p_rd_busy; mem_req.rd_en |-> engine_busy; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read while idle");
  // Tests never stall or abort mid-byte, so a read always ends in a write
  property p_rd_to_wr; mem_req.rd_en |-> ##[2:3] mem_req.wr_en; endproperty
  a_rd_to_wr: assert property (p_rd_to_wr) else $error("read without write");
  property p_start_read; $rose(engine_busy) |-> ##[0:3] mem_req.rd_en; endproperty
  a_start_read: assert property (p_start_read) else $error("busy without read");
  c_write: cover property (mem_req.wr_en);
  c_irq: cover property ($rose(irq));
  c_overlap: cover property (|overlap_error);
  c_count: cover property (|count_range_error);
endmodule // mbt_top_chk

bind mbt_top mbt_top_chk #(.MEM_BYTES(MEM_BYTES)) i_chk (.hclk(hclk), .hresetn(hresetn),
  .ce(ce), .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .mem_req(mem_req), .irq(irq), .engine_busy(engine_busy),
  .count_range_error(count_range_error), .overlap_error(overlap_error));

// File: mbt_mem_model.sv
// Byte-wide synchronous marker memory with one cycle read latency
`timescale 1ns/100ps
module mbt_mem_model #(
  parameter int MEM_BYTES = 512
) (
  // Clock
  input wire logic hclk,
  // Byte port
  input wire mbt_pkg::mbt_mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [MEM_BYTES];
  initial begin
    for (int k = 0; k < MEM_BYTES; k++) mem[k] = 8'(k) ^ 8'h3C;
    mem_rdata = 8'h00;
  end
  // Data not held after its cycle, so a late sample sees junk
  always @(posedge hclk) begin
    if (mem_req.rd_en) mem_rdata <= mem[mem_req.addr];
    else mem_rdata <= ~mem_rdata;
    if (mem_req.wr_en) mem[mem_req.addr] <= mem_req.wdata;
  end
endmodule // mbt_mem_model

// File: test_mbt_top.sv
// Self-checking bench of the marker block transfer engine
`timescale 1ns/100ps
module test_mbt_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, irq, engine_busy;
  logic [31:0] count_range_error, overlap_error, marker_bounds_error;
  logic [7:0] mem_rdata;
  logic [7:0] sv [4];
  mbt_pkg::mbt_mem_req_t mem_req;
  int error_cnt = 0, comparisons = 0, rd_cnt = 0, n0;
  int tsrc [8] = '{0, 0, 0, 0, 0, 0, 8, 5};
  int tdst [8] = '{100, 2, 511, 510, 100, 100, 7, 7};
  int tcnt [8] = '{4, 4, 1, 4, 0, 1025, 4, 4};
  logic [3:0] tctl [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4};
  logic [2:0] texp [8] = '{3'h0, 3'h2, 3'h0, 3'h1, 3'h4, 3'h1, 3'h2, 3'h0};
  logic [2:0] tmsk [8] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h4, 3'h1, 3'h2, 3'h7};

  always #25 hclk = ~hclk;
  always @(posedge hclk) if (mem_req.rd_en === 1'b1) rd_cnt <= rd_cnt + 1;

  mbt_top #(.MEM_BYTES(512)) i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .irq(irq), .engine_busy(engine_busy),
    .count_range_error(count_range_error), .overlap_error(overlap_error),
    .marker_bounds_error(marker_bounds_error));
  mbt_mem_model #(.MEM_BYTES(512)) i_mem (.hclk(hclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic close_out;
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input int a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100);
    rd = hrdata;
  endtask
  task automatic cfg(input int ch, input int s, input int d, input int c, input logic [3:0] t);
    bus(1'b1, ch * 16 + int'(mbt_pkg::REG_SRC), 32'(s));
    bus(1'b1, ch * 16 + int'(mbt_pkg::REG_DST), 32'(d));
    bus(1'b1, ch * 16 + int'(mbt_pkg::REG_CNT), 32'(c));
    bus(1'b1, ch * 16 + int'(mbt_pkg::REG_CTRL), 32'(t));
  endtask
  // Polls status a bounded number of times, then clears what it found
  task automatic wait_done(input int ch, input logic done, input logic irq_exp);
    int n;
    n = 0;
    do begin bus(1'b0, 32'h200, 32'h0); n++; end while (rd[ch] !== 1'b1 && n < 30);
    check(32'(rd[ch]), 32'(done));
    if (rd[ch] === 1'b1) begin
      check(32'(irq), 32'(irq_exp));
      bus(1'b1, 32'h200, 32'h1 << ch);
      bus(1'b0, 32'h200, 32'h0);
      check(rd | 32'(irq) | 32'(engine_busy), 32'h0);
    end
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check(marker_bounds_error, 32'hFFFFFFFF);
    check(overlap_error | count_range_error, 32'h0);
    bus(1'b0, 32'h204, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 32'h300, 32'hFFFFFFFF);
    bus(1'b0, 32'h300, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      cfg(6, tsrc[i], tdst[i], tcnt[i], tctl[i]);
      bus(1'b0, 6 * 16 + 12, 32'h0);
      check(32'(rd[10:8] & tmsk[i]), 32'(texp[i]));
      check(32'({marker_bounds_error[6], overlap_error[6], count_range_error[6]} & tmsk[i]),
        32'(texp[i]));
    end
    for (int k = 0; k < 4; k++) sv[k] = i_mem.mem[k];
    // Marker byte one addressed by offset zero
    cfg(0, (1 - 1) * 2, 10, 4, 4'h9);
    bus(1'b1, 12, 32'hB);
    wait_done(0, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) check(32'(i_mem.mem[10 + k]), 32'(sv[k]));
    bus(1'b1, 32'h204, 32'hFFFFFFFF);
    bus(1'b1, 12, 32'hB);
    wait_done(0, 1'b0, 1'b0);
    bus(1'b1, 12, 32'h9);
    wait_done(0, 1'b0, 1'b0);
    sv[0] = i_mem.mem[20];
    n0 = rd_cnt;
    cfg(5, 20, 30, 3, 4'h4);
    bus(1'b1, 5 * 16 + 12, 32'h6);
    wait_done(5, 1'b1, 1'b1);
    check(32'(rd_cnt - n0), 32'h1);
    for (int k = 0; k < 3; k++) check(32'(i_mem.mem[30 + k]), 32'(sv[0]));
    cfg(2, 0, 40, 2, 4'h8);
    bus(1'b1, 2 * 16 + 12, 32'hA);
    wait_done(2, 1'b0, 1'b0);
    sv[0] = i_mem.mem[2];
    cfg(31, 0, 2, 4, 4'h1);
    bus(1'b1, 31 * 16 + 12, 32'h3);
    wait_done(31, 1'b0, 1'b0);
    check(32'(i_mem.mem[2]), 32'(sv[0]));
    check(32'(overlap_error[31]), 32'h1);
    for (int k = 0; k < 4; k++) sv[k] = i_mem.mem[k];
    cfg(31, 0, 200, 4, 4'h1);
    bus(1'b1, 31 * 16 + 12, 32'h3);
    wait_done(31, 1'b1, 1'b1);
    for (int k = 0; k < 4; k++) check(32'(i_mem.mem[200 + k]), 32'(sv[k]));
    close_out;
  end
endmodule // test_mbt_top
